// ===== compare_convert_params.svh
`ifndef COMPARE_CONVERT_PARAMS_SVH
`define COMPARE_CONVERT_PARAMS_SVH

// ****************************************************************
// Register map, byte addresses on the AXI4-Lite slave
// ****************************************************************
`define CC_OFS_CTRL      8'h00
`define CC_OFS_STATUS    8'h04
`define CC_OFS_MASK      8'h08
`define CC_OFS_RESULT    8'h0c
`define CC_OFS_FLAGS     8'h10

// ****************************************************************
// Field positions
// ****************************************************************
`define CC_CTRL_ENABLE   0
`define CC_EVT_DONE      0
`define CC_EVT_ERROR     1
`define CC_FLAG_ERROR    0
`define CC_FLAG_EQUAL    1

// ****************************************************************
// Reset values and sizes
// ****************************************************************
`define CC_CTRL_RESET    32'h0000_0001
`define CC_MASK_RESET    2'h0
`define CC_TABLE_WORDS   16
`define CC_RANGE_WORDS   32
`define CC_BCD_SCALE     32'h0000_2710
`define CC_RESP_OKAY     2'h0
`define CC_RESP_SLVERR   2'h2

`endif

// ===== compare_convert_pkg.sv
package compare_convert_pkg;

  // Operation select, one-hot.
  typedef enum logic [3:0] {
    OP_TABLE_EQUAL_COMPARE  = 4'h1,
    OP_RANGE_BLOCK_COMPARE  = 4'h2,
    OP_BCD_TO_BINARY_SINGLE = 4'h4,
    OP_BCD_TO_BINARY_DOUBLE = 4'h8
  } op_t;

  // Operand set handed over by the sequencer for one execution.
  typedef struct packed {
    op_t         op;
    logic [15:0] compareWord;
    logic [15:0] sourceLo;
    logic [15:0] sourceHi;
    logic [15:0] tableFirstWord;
    logic [15:0] areaLastWord;
    logic        indirect;
    logic [15:0] pointerWord;
  } cc_request_t;

  // Result words and flags as held by the block.
  typedef struct packed {
    logic [15:0] resultLo;
    logic [15:0] resultHi;
    logic        errorFlag;
    logic        equalFlag;
  } cc_result_t;

endpackage

// ===== bcd4_to_bin.sv
`timescale 1ns/1ps

// ****************************************************************
// Four-digit BCD word to binary, with digit check
// ****************************************************************
module bcd4_to_bin
(
  // BCD word in
  input  wire logic [15:0] bcdWord,
  // Binary value and validity out
  output logic      [13:0] binValue,
  output logic             digitsValid
);

  // Weighted sum of the digits; every digit above nine marks the word invalid.
  always_comb
  begin
    binValue    = 14'(bcdWord[15:12]) * 14'h3e8 + 14'(bcdWord[11:8]) * 14'h064
                + 14'(bcdWord[7:4]) * 14'h00a + 14'(bcdWord[3:0]);
    digitsValid = (bcdWord[15:12] <= 4'h9) && (bcdWord[11:8] <= 4'h9)
                && (bcdWord[7:4] <= 4'h9) && (bcdWord[3:0] <= 4'h9);
  end

endmodule // bcd4_to_bin

// ===== compare_convert_datapath.sv
`timescale 1ns/1ps
`include "compare_convert_params.svh"

// Contract
// RULE_01: Condition false: no operation, nothing changes.
// RULE_02: Table compare sets bit n on equality.
// RULE_03: Each table entry judged on its own.
// RULE_04: Unequal entries clear their bit each time.
// RULE_05: Table past area end raises error.
// RULE_06: Bad indirect pointer raises error.
// RULE_07: Condition true: fresh result every scan. Code: only while the CTRL enable bit is set.
// RULE_08: Single conversion writes binary result word.
// RULE_09: Invalid BCD digit raises error, single.
// RULE_10: Double conversion: eight digits to 32 bits.
// RULE_11: Invalid digit in either word raises error.
// RULE_12: Equal flag true when conversion gives zero.
// RULE_13: Sources never written, only results.
// RULE_14: Range compare: inclusive limit pairs set bits.
// RULE_15: On error result words stay unchanged.
// RULE_16: Lower word holds low digits and bits.
module compare_convert_datapath
  import compare_convert_pkg::*;
(
  // Clock and reset
  input  wire logic                   clk,
  input  wire logic                   srst,
  // Sequencer side
  input  wire logic                   execCond,
  input  wire logic                   scanStrobe,
  input  wire cc_request_t            request,
  input  wire logic [31:0][15:0]      tableWords,
  output cc_result_t                  result,
  output logic                        opDone,
  // AXI4-Lite write channels
  input  wire logic [7:0]             s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  // AXI4-Lite read channels
  input  wire logic [7:0]             s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  // Interrupt
  output logic                        irq
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic [2:0][13:0] bcdBin;
  logic [2:0]       bcdValid;
  logic [15:0]      tableMask;
  logic [15:0]      rangeMask;
  logic             tableOverrun;
  logic             rangeOverrun;
  logic             pointerBad;
  logic [31:0]      doubleBin;
  logic             next_error;
  logic             isConvert;
  logic [15:0]      next_lo;
  logic [15:0]      next_hi;
  logic             execute;
  logic [31:0]      ctrl;
  logic [1:0]       status;
  logic [1:0]       mask;
  logic [1:0]       eventSet;
  logic [1:0]       eventClear;
  logic [1:0]       next_status;
  logic             awHeld;
  logic             wHeld;
  logic [7:0]       awAddr;
  logic [31:0]      wData;
  logic [3:0]       wStrb;
  logic             doWrite;
  logic             readTaken;
  logic [31:0]      readMux;
  logic             readHit;
  logic [2:0][15:0] convWords;

  // ****************************************************************
  // BCD decoders: source low, source high, indirect pointer
  // ****************************************************************
  assign convWords = {request.pointerWord, request.sourceHi, request.sourceLo};
  for (genvar g = 0; g < 3; g++)
  begin : gen_bcd
    bcd4_to_bin u_bcd
    (
      .bcdWord     (convWords[g]),
      .binValue    (bcdBin[g]),
      .digitsValid (bcdValid[g])
    );
  end

  // ****************************************************************
  // Operation evaluation
  // ****************************************************************
  // Every entry gets its own comparator, so duplicate entries all report a hit.
  always_comb
  begin
    tableMask = 16'h0000;
    rangeMask = 16'h0000;
    for (int i = 0; i < `CC_TABLE_WORDS; i++)
    begin
      tableMask[i] = (tableWords[i] == request.compareWord); // RULE_02 RULE_03 RULE_04
      rangeMask[i] = (tableWords[2*i] <= request.compareWord)
                   && (request.compareWord <= tableWords[2*i+1]); // RULE_14
    end
  end

  // Span checks run on 17 bits so a table near the top of memory cannot wrap.
  assign tableOverrun = ({1'b0, request.tableFirstWord} + 17'(`CC_TABLE_WORDS - 1))
                      > {1'b0, request.areaLastWord}; // RULE_05
  assign rangeOverrun = ({1'b0, request.tableFirstWord} + 17'(`CC_RANGE_WORDS - 1))
                      > {1'b0, request.areaLastWord};
  assign pointerBad   = request.indirect
                      && (!bcdValid[2] || ({2'b00, bcdBin[2]} > request.areaLastWord)); // RULE_06

  // High word carries the upper four digits, low word the lower four.
  assign doubleBin = 32'(bcdBin[1]) * `CC_BCD_SCALE + 32'(bcdBin[0]); // RULE_10 RULE_16

  // Error and candidate result for the selected operation.
  always_comb
  begin
    next_error = 1'b1;
    isConvert  = 1'b0;
    next_lo    = result.resultLo;
    next_hi    = result.resultHi;
    unique case (request.op)
      OP_TABLE_EQUAL_COMPARE:
      begin
        next_error = tableOverrun || pointerBad;
        next_lo    = tableMask;
      end
      OP_RANGE_BLOCK_COMPARE:
      begin
        next_error = rangeOverrun || pointerBad;
        next_lo    = rangeMask;
      end
      OP_BCD_TO_BINARY_SINGLE:
      begin
        next_error = !bcdValid[0] || pointerBad; // RULE_09
        isConvert  = 1'b1;
        next_lo    = {2'b00, bcdBin[0]}; // RULE_08
      end
      OP_BCD_TO_BINARY_DOUBLE:
      begin
        next_error = !bcdValid[0] || !bcdValid[1] || pointerBad; // RULE_11
        isConvert  = 1'b1;
        next_lo    = doubleBin[15:0]; // RULE_16
        next_hi    = doubleBin[31:16];
      end
      default: next_error = 1'b1;
    endcase
  end

  // Software can park the block; the sequencer condition gates each scan.
  assign execute = scanStrobe && execCond && ctrl[`CC_CTRL_ENABLE]; // RULE_01 RULE_07

  // ****************************************************************
  // Result words and flags
  // ****************************************************************
  // Only the result words, flags and done pulse are held here; operand words are never written back.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      result <= '0;
      opDone <= 1'b0;
    end
    else
    begin
      opDone <= execute;
      if (execute) // RULE_01 RULE_07
      begin
        result.errorFlag <= next_error;
        if (!next_error) // RULE_15
        begin
          result.resultLo <= next_lo; // RULE_13
          if (request.op == OP_BCD_TO_BINARY_DOUBLE)
            result.resultHi <= next_hi;
          if (isConvert)
            result.equalFlag <= (request.op == OP_BCD_TO_BINARY_DOUBLE) ? (doubleBin == 32'h0)
                                                                       : (next_lo == 16'h0); // RULE_12
        end
      end
    end
  end

  // ****************************************************************
  // Interrupt status, set wins over read-clear
  // ****************************************************************
  assign eventSet    = {execute && next_error, execute};
  assign eventClear  = (readTaken && (s_axi_araddr == `CC_OFS_STATUS)) ? status : 2'b00;
  assign next_status = (status & ~eventClear) | eventSet;

  // The interrupt trails the status bits by one cycle so that it leaves a flop.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      status <= 2'b00;
      irq    <= 1'b0;
    end
    else
    begin
      status <= next_status;
      irq    <= |(status & mask);
    end
  end

  // ****************************************************************
  // AXI4-Lite write path
  // ****************************************************************
  assign doWrite = awHeld && wHeld && !s_axi_bvalid;

  // Address and data are latched independently, one write at a time.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      awHeld        <= 1'b0;
      wHeld         <= 1'b0;
      awAddr        <= 8'h00;
      wData         <= 32'h0;
      wStrb         <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `CC_RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        awHeld        <= 1'b1;
        awAddr        <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wHeld        <= 1'b1;
        wData        <= s_axi_wdata;
        wStrb        <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (doWrite)
      begin
        awHeld       <= 1'b0;
        wHeld        <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (awAddr == `CC_OFS_CTRL || awAddr == `CC_OFS_MASK || awAddr == `CC_OFS_STATUS
                        || awAddr == `CC_OFS_RESULT || awAddr == `CC_OFS_FLAGS) ? `CC_RESP_OKAY
                                                                                 : `CC_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // Writable registers honour byte strobes; the other words ignore writes.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      ctrl <= `CC_CTRL_RESET;
      mask <= `CC_MASK_RESET;
    end
    else if (doWrite)
    begin
      if (awAddr == `CC_OFS_CTRL)
        for (int b = 0; b < 4; b++)
          if (wStrb[b])
            ctrl[8*b +: 8] <= wData[8*b +: 8];
      if (awAddr == `CC_OFS_MASK && wStrb[0])
        mask <= wData[1:0];
    end
  end

  // ****************************************************************
  // AXI4-Lite read path
  // ****************************************************************
  assign readTaken = s_axi_arvalid && s_axi_arready;

  // Read data multiplexer; unused bits read as zero.
  always_comb
  begin
    readHit = 1'b1;
    readMux = 32'h0;
    unique case (s_axi_araddr)
      `CC_OFS_CTRL:   readMux = ctrl;
      `CC_OFS_STATUS: readMux = {30'h0, status};
      `CC_OFS_MASK:   readMux = {30'h0, mask};
      `CC_OFS_RESULT: readMux = {result.resultHi, result.resultLo};
      `CC_OFS_FLAGS:  readMux = {30'h0, result.equalFlag, result.errorFlag};
      default:        readHit = 1'b0;
    endcase
  end

  // The address is taken and answered on the next edge.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= `CC_RESP_OKAY;
    end
    else
    begin
      if (readTaken)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= readMux;
        s_axi_rresp   <= readHit ? `CC_RESP_OKAY : `CC_RESP_SLVERR;
      end
      if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule // compare_convert_datapath

// ===== scan_sequencer.sv
`timescale 1ns/1ps

// ****************
// Sequencer model
// ****************
module scan_sequencer
  import compare_convert_pkg::*;
(
  // Clock
  input  wire logic  clk,
  // Operation request
  output logic        execCond,
  output logic        scanStrobe,
  output cc_request_t request
);
  // Quiet until the first scan.
  initial
  begin
    execCond = 1'b0;
    scanStrobe = 1'b0;
    request = '0;
  end

  // One scan, held for the strobe edge only. Afterwards the operands turn to
  // their inverse, so that a late sample of them is caught.
  task automatic scan(input logic c, input cc_request_t r);
    @(posedge clk);
    execCond <= c;
    scanStrobe <= 1'b1;
    request <= r;
    @(posedge clk);
    execCond <= ~c;
    scanStrobe <= 1'b0;
    request <= ~r;
  endtask
endmodule // scan_sequencer

// ===== compare_convert_assertions.sv
`timescale 1ns/1ps

// ****************
// Port checker
// ****************
module compare_convert_checker
  import compare_convert_pkg::*;
(
  // Clock and reset
  input wire logic              clk,
  input wire logic              srst,
  // Sequencer side
  input wire logic              execCond,
  input wire logic              scanStrobe,
  input wire cc_request_t       request,
  input wire logic [31:0][15:0] tableWords,
  input wire cc_result_t        result,
  input wire logic              opDone
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  // Digit check and decimal value of a four-digit word.
  function automatic logic ok4(input logic [15:0] w);
    return w[15:12] < 4'ha && w[11:8] < 4'ha && w[7:4] < 4'ha && w[3:0] < 4'ha;
  endfunction
  function automatic logic [31:0] val4(input logic [15:0] w);
    return 32'(w[15:12]) * 32'd1000 + 32'(w[11:8]) * 32'd100 + 32'(w[7:4]) * 32'd10 + 32'(w[3:0]);
  endfunction

  cc_request_t q;
  logic [15:0] tMask;
  logic [15:0] rMask;
  logic        go;
  logic        pErr;
  logic        tErr;
  logic        rErr;
  logic        cErr;
  logic        isConv;
  logic        isDbl;
  logic [31:0] cVal;

  // Reference masks, each entry judged on its own.
  always_comb
  begin
    for (int i = 0; i < 16; i++)
    begin
      tMask[i] = tableWords[i] == q.compareWord;
      rMask[i] = tableWords[2*i] <= q.compareWord && q.compareWord <= tableWords[2*i+1];
    end
  end

  // Error causes and the expected conversion value.
  assign q = request;
  assign go = scanStrobe && execCond;
  assign isDbl = q.op == OP_BCD_TO_BINARY_DOUBLE;
  assign isConv = isDbl || q.op == OP_BCD_TO_BINARY_SINGLE;
  assign pErr = q.indirect && (!ok4(q.pointerWord) || val4(q.pointerWord) > 32'(q.areaLastWord));
  assign tErr = pErr || 32'(q.tableFirstWord) + 32'd15 > 32'(q.areaLastWord);
  assign rErr = pErr || 32'(q.tableFirstWord) + 32'd31 > 32'(q.areaLastWord);
  assign cErr = pErr || !ok4(q.sourceLo) || (isDbl && !ok4(q.sourceHi));
  assign cVal = isDbl ? val4(q.sourceHi) * 32'd10000 + val4(q.sourceLo) : val4(q.sourceLo);

  // An executed scan, answered one cycle later.
  sequence sRun(c);
    go && c ##1 opDone;
  endsequence

  chk_idle_hold: assert property (!go |=> $stable(result) && !opDone)
    else $error("result moved without an executed scan");
  chk_table_mask: assert property (sRun(q.op == OP_TABLE_EQUAL_COMPARE && !tErr)
    |-> result.resultLo == $past(tMask) && !result.errorFlag)
    else $error("table mask wrong");
  chk_table_error: assert property (sRun(q.op == OP_TABLE_EQUAL_COMPARE && tErr)
    |-> result.errorFlag && $stable(result.resultLo))
    else $error("table overrun not refused");
  chk_pointer_error: assert property (sRun(pErr) |-> result.errorFlag)
    else $error("bad pointer not flagged");
  chk_range_mask: assert property (sRun(q.op == OP_RANGE_BLOCK_COMPARE && !rErr)
    |-> result.resultLo == $past(rMask))
    else $error("range mask wrong");
  chk_conv_value: assert property (sRun(isConv && !cErr) |-> result.resultLo == 16'($past(cVal)))
    else $error("converted value wrong");
  chk_conv_equal: assert property (sRun(isConv && !cErr) |-> result.equalFlag == ($past(cVal) == 32'd0))
    else $error("equal flag wrong");
  chk_double_high: assert property (sRun(isDbl && !cErr) |-> result.resultHi == 16'($past(cVal) >> 16))
    else $error("high result word wrong");
  chk_digit_error: assert property (sRun(isConv && cErr)
    |-> result.errorFlag && $stable(result.resultLo) && $stable(result.equalFlag))
    else $error("bad digit not refused");
endmodule // compare_convert_checker

bind compare_convert_datapath compare_convert_checker chk (.clk(clk), .srst(srst), .execCond(execCond),
  .scanStrobe(scanStrobe), .request(request), .tableWords(tableWords), .result(result), .opDone(opDone));

// ===== tb_top.sv
`timescale 1ns/1ps

// ****************
// Bench top
// ****************
module tb_top
  import compare_convert_pkg::*;
;
  logic              clk = 1'b0;
  logic              srst = 1'b1;
  logic [31:0][15:0] tbl = '0;
  logic [7:0]        awaddr = '0;
  logic [7:0]        araddr = '0;
  logic [31:0]       wdata = '0;
  logic              awvalid = 1'b0;
  logic              wvalid = 1'b0;
  logic              bready = 1'b0;
  logic              arvalid = 1'b0;
  logic              rready = 1'b0;
  logic              awready, wready, bvalid, arready, rvalid;
  logic              execCond, scanStrobe, opDone, irq;
  logic [1:0]        bresp, rresp;
  logic [31:0]       rdata;
  cc_request_t       request, rq;
  cc_result_t        result;
  int                numErrors = 0;
  int                checksDone = 0;

  scan_sequencer seq (.clk(clk), .execCond(execCond), .scanStrobe(scanStrobe), .request(request));
  compare_convert_datapath uut (.clk(clk), .srst(srst), .execCond(execCond), .scanStrobe(scanStrobe),
    .request(request), .tableWords(tbl), .result(result), .opDone(opDone), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq(irq));

  // Clock, 100 ns period.
  always #50 clk = ~clk;

  task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
    checksDone++;
    if (seen !== exp)
    begin
      numErrors++;
      $display("wrong value %s expected %h seen %h", n, exp, seen);
    end
  endtask

  task automatic wrapUp;
    $display("checks %0d errors %0d", checksDone, numErrors);
    if (numErrors == 0 && checksDone > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Bus write: each channel released once taken, the response held for.
  task automatic axWrite(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    check("write resp", 32'(bresp), 32'(er));
    bready <= 1'b0;
  endtask

  task automatic axRead(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  // One scan with the current operands; the answer lands one edge later.
  task automatic exec(input logic c);
    seq.scan(c, rq);
    #1;
    check("done pulse", opDone, c);
  endtask

  task automatic tRegs;
    logic [31:0] d;
    logic [1:0]  r;
    axRead(8'h00, d, r);
    check("ctrl reset", d, 32'h1);
    axRead(8'h04, d, r);
    check("status reset", d, 32'h0);
    axRead(8'h20, d, r);
    check("unmapped resp", 32'(r), 32'h2);
    axWrite(8'h20, 32'h0, 2'h2);
    rq = '0;
    axWrite(8'h00, 32'h0, 2'h0);
    seq.scan(1'b1, rq);
    #1 check("parked done", opDone, 1'b0);
    check("parked error", result.errorFlag, 1'b0);
    axWrite(8'h00, 32'h1, 2'h0);
  endtask

  // Duplicates, a rerun with one entry changed, overrun and pointer limits.
  task automatic tTable;
    logic [15:0] ptr [3] = '{16'h00a0, 16'h0016, 16'h0015};
    rq = '0;
    rq.op = OP_TABLE_EQUAL_COMPARE;
    rq.compareWord = 16'h0210;
    rq.areaLastWord = 16'h000f;
    @(posedge clk);
    for (int i = 0; i < 16; i++) tbl[i] <= (i % 4 == 2) ? 16'h0210 : 16'h0100 + 16'(i);
    exec(1'b1);
    check("table mask", result.resultLo, 16'h4444);
    check("table ok", result.errorFlag, 1'b0);
    @(posedge clk);
    tbl[6] <= 16'h0000;
    exec(1'b1);
    check("table rerun", result.resultLo, 16'h4404);
    rq.areaLastWord = 16'h000e;
    exec(1'b1);
    check("table overrun", result.errorFlag, 1'b1);
    check("table kept", result.resultLo, 16'h4404);
    rq.areaLastWord = 16'h000f;
    rq.indirect = 1'b1;
    for (int i = 0; i < 3; i++)
    begin
      rq.pointerWord = ptr[i];
      exec(1'b1);
      check("pointer error", result.errorFlag, i < 2);
    end
    @(posedge clk);
    tbl[6] <= 16'h0210;
    exec(1'b0);
    check("idle kept", result.resultLo, 16'h4404);
  endtask

  // Both limits inclusive; the third pair starts one above the value.
  task automatic tRange;
    logic [15:0] lim [6] = '{16'h0210, 16'h0300, 16'h0100, 16'h0210, 16'h0211, 16'h0400};
    rq = '0;
    rq.op = OP_RANGE_BLOCK_COMPARE;
    rq.compareWord = 16'h0210;
    rq.areaLastWord = 16'h001f;
    @(posedge clk);
    for (int i = 0; i < 32; i++) tbl[i] <= i < 6 ? lim[i] : 16'hffff;
    exec(1'b1);
    check("range mask", result.resultLo, 16'h0003);
    rq.areaLastWord = 16'h001e;
    exec(1'b1);
    check("range overrun", result.errorFlag, 1'b1);
    check("range kept", result.resultLo, 16'h0003);
  endtask

  task automatic tConv;
    logic [15:0] src [4] = '{16'h9999, 16'h0000, 16'h12a4, 16'h0001};
    logic [15:0] bin [4] = '{16'h270f, 16'h0000, 16'h0000, 16'h0001};
    rq = '0;
    rq.op = OP_BCD_TO_BINARY_SINGLE;
    for (int i = 0; i < 4; i++)
    begin
      rq.sourceLo = src[i];
      exec(1'b1);
      check("single value", result.resultLo, bin[i]);
      check("single equal", result.equalFlag, i == 1 || i == 2);
      check("single error", result.errorFlag, i == 2);
    end
    rq.op = OP_BCD_TO_BINARY_DOUBLE;
    rq.sourceHi = 16'h1234;
    rq.sourceLo = 16'h5678;
    exec(1'b1);
    check("double value", {result.resultHi, result.resultLo}, 32'h00bc614e);
    rq.sourceHi = 16'h1f00;
    exec(1'b1);
    check("double error", result.errorFlag, 1'b1);
    check("double kept", {result.resultHi, result.resultLo}, 32'h00bc614e);
    rq.op = op_t'(4'h3);
    exec(1'b1);
    check("bad op error", result.errorFlag, 1'b1);
    check("bad op kept", {result.resultHi, result.resultLo}, 32'h00bc614e);
  endtask

  // Done event raises the line when masked in, a status read clears it.
  task automatic tIrq;
    logic [31:0] d;
    logic [1:0]  r;
    rq.op = OP_BCD_TO_BINARY_DOUBLE;
    rq.sourceHi = 16'h0000;
    axRead(8'h04, d, r);
    axWrite(8'h08, 32'h1, 2'h0);
    exec(1'b1);
    repeat (2) @(posedge clk);
    #1 check("irq raised", irq, 1'b1);
    axRead(8'h04, d, r);
    check("status done", d, 32'h1);
    repeat (2) @(posedge clk);
    #1 check("irq cleared", irq, 1'b0);
    axWrite(8'h08, 32'h0, 2'h0);
    exec(1'b1);
    repeat (2) @(posedge clk);
    #1 check("irq masked", irq, 1'b0);
  endtask

  // Main sequence.
  initial
  begin
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    tRegs();
    tTable();
    tRange();
    tConv();
    tIrq();
    wrapUp();
  end

  // Watchdog, far beyond the hundred or so cycles the tests need.
  initial
  begin
    #400000;
    numErrors++;
    wrapUp();
  end
endmodule // tb_top
